// ===== design/eosf_regs.svh
// register offsets, field positions and reset values for the overhead source and framing block
`ifndef EOSF_REGS_SVH
`define EOSF_REGS_SVH
`define EOSF_ADDR_W        12
`define EOSF_TSDL_OFS      12'h10a
`define EOSF_FCR_OFS       12'h10b
`define EOSF_SRCX_OFS      12'h10c
`define EOSF_STAT_OFS      12'h10d
`define EOSF_TSDL_RST      8'h00
`define EOSF_FCR_RST       8'h40
`define EOSF_SRCX_RST      8'h00
`define EOSF_SEL_LSB       0
`define EOSF_SEL_MSB       2
`define EOSF_REFRAME_BIT   7
`define EOSF_CASC_LSB      5
`define EOSF_CASC_MSB      6
`define EOSF_CODE_DL       3'h0
`define EOSF_CODE_CAS_DL   3'h1
`define EOSF_CODE_ONES     3'h2
`define EOSF_CODE_CAS_ONES 3'h3
`define EOSF_CODE_SIG_DE   3'h4
`define EOSF_CASC_2        2'h0
`define EOSF_CASC_3        2'h1
`define EOSF_CASC_4        2'h2
`define EOSF_CASC_8        2'h3
`define EOSF_CNT_2         4'h2
`define EOSF_CNT_3         4'h3
`define EOSF_CNT_4         4'h4
`define EOSF_CNT_8         4'h8
`define EOSF_ALT_PIN_BIT   2
`define EOSF_TS16_SRC_LSB  0
`define EOSF_TS16_SRC_MSB  1
`endif

// ===== design/eosf_pkg.sv
// types shared by the overhead source and framing control block
package eosf_pkg;
    // slot strobes from the transmit frame timing logic, same clock
    typedef struct packed {
        logic nat_bit;   // national bit position of a non-fas timeslot 0
        logic de_slot;   // d/e channel bit position
        logic ts16;      // timeslot 16 bit position
    } eosf_slot_s;
    // events from the receive framer, same clock
    typedef struct packed {
        logic in_sync;   // level: framer holds alignment
        logic mfas_ok;   // pulse: cas multiframe word good
        logic mfas_err;  // pulse: cas multiframe word errored
    } eosf_rx_s;
    typedef enum logic [1:0] {
        EOSF_TS16_SERIAL,
        EOSF_TS16_SLOTREG,
        EOSF_TS16_OVERHEAD,
        EOSF_TS16_SIGNAL
    } eosf_ts16_src_e;
endpackage

// ===== design/eosf_ctrl.sv
// transmit overhead source select and receive framing control
`timescale 1ns/1ps
`include "eosf_regs.svh"

module eosf_ctrl (
    input  wire logic                      clk,               // framer clock, 125 mhz
    input  wire logic                      rst_n,             // synchronous reset
    input  wire logic [`EOSF_ADDR_W-1:0]   reg_addr,          // register address
    input  wire logic [7:0]                reg_wdata,         // write data
    input  wire logic                      reg_wr,            // write strobe
    input  wire logic                      reg_rd,            // read strobe
    output logic      [7:0]                reg_rdata_q,       // read data, cycle after strobe
    input  wire logic                      tx_frame_data_in,  // backplane frame-data pin
    input  wire logic                      tx_serial_in,      // backplane serial pin
    input  wire logic                      tx_signalling_in,  // backplane signalling pin
    input  wire logic                      tx_overhead_in,    // backplane overhead pin
    input  wire logic                      dl_bit,            // data link bit, same clock
    input  wire logic                      slot_sig_bit,      // per_slot_signalling_regs bit
    input  wire eosf_pkg::eosf_slot_s      slot,              // transmit slot strobes
    input  wire eosf_pkg::eosf_rx_s        rx_ev,             // receive framer events
    output logic                           tx_out_q,          // selected outbound bit
    output logic                           rx_restart_q,      // restart frame search pulse
    output logic                           cas_loss_q         // loss of cas mf alignment
);
    import eosf_pkg::*;

    logic [7:0]      tsdl_q;
    logic [7:0]      fcr_q;
    logic [7:0]      srcx_q;
    logic [3:0]      pin_s1_q;
    logic [3:0]      pin_s2_q;
    logic            sync_prev_q;
    logic [3:0]      err_cnt_q;
    logic [3:0]      err_thr;
    logic            tx_bit_d;
    logic [2:0]      code;
    logic [1:0]      casc;
    logic            wr_tsdl;
    logic            wr_fcr;
    logic            sync_rise;
    logic            ser_s;
    logic            fd_s;
    logic            sig_s;
    logic            oh_s;
    eosf_ts16_src_e  ts16_src;

    assign wr_tsdl   = reg_wr && (reg_addr == `EOSF_TSDL_OFS);
    assign wr_fcr    = reg_wr && (reg_addr == `EOSF_FCR_OFS);
    assign code      = tsdl_q[`EOSF_SEL_MSB:`EOSF_SEL_LSB];
    assign casc      = fcr_q[`EOSF_CASC_MSB:`EOSF_CASC_LSB];
    assign ts16_src  = eosf_ts16_src_e'(srcx_q[`EOSF_TS16_SRC_MSB:`EOSF_TS16_SRC_LSB]);
    assign sync_rise = rx_ev.in_sync && !sync_prev_q;
    // pins after the second synchroniser stage only
    assign ser_s     = pin_s2_q[0];
    assign fd_s      = pin_s2_q[1];
    assign sig_s     = pin_s2_q[2];
    assign oh_s      = pin_s2_q[3];

    // backplane pins come from another domain, two flops before use
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
        end else begin
            pin_s1_q <= {tx_overhead_in, tx_signalling_in, tx_frame_data_in, tx_serial_in};
            pin_s2_q <= pin_s1_q;
        end
    end

    // source select and its companion source register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tsdl_q <= `EOSF_TSDL_RST;
            srcx_q <= `EOSF_SRCX_RST;
        end else begin
            if (wr_tsdl) begin
                tsdl_q <= reg_wdata;
            end
            if (reg_wr && (reg_addr == `EOSF_SRCX_OFS)) begin
                srcx_q <= reg_wdata;
            end
        end
    end

    // framing control; the hardware clear loses to a write of one
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fcr_q <= `EOSF_FCR_RST;
        end else if (wr_fcr) begin
            fcr_q <= reg_wdata;
        end else if (sync_rise) begin
            fcr_q[`EOSF_REFRAME_BIT] <= 1'b0;
        end
    end

    // restart pulse to the receive framer, one cycle per write of one
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_restart_q <= 1'b0;
            sync_prev_q  <= 1'b0;
        end else begin
            rx_restart_q <= wr_fcr && reg_wdata[`EOSF_REFRAME_BIT];
            sync_prev_q  <= rx_ev.in_sync;
        end
    end

    // threshold of consecutive errored cas multiframe words
    always_comb begin
        case (casc)
            `EOSF_CASC_2: err_thr = `EOSF_CNT_2;
            `EOSF_CASC_3: err_thr = `EOSF_CNT_3;
            `EOSF_CASC_4: err_thr = `EOSF_CNT_4;
            default:      err_thr = `EOSF_CNT_8;
        endcase
    end

    // count runs of errored words; a good word or a restart ends the run,
    // but an errored word in the same cycle wins so a defect is never lost
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            err_cnt_q  <= 4'h0;
            cas_loss_q <= 1'b0;
        end else if (rx_ev.mfas_err) begin
            // saturate so a long outage cannot wrap back below threshold
            if (err_cnt_q < err_thr) begin
                err_cnt_q <= err_cnt_q + 4'h1;
            end
            if (err_cnt_q + 4'h1 >= err_thr) begin
                cas_loss_q <= 1'b1;
            end
        end else if (rx_ev.mfas_ok || rx_restart_q) begin
            err_cnt_q  <= 4'h0;
            cas_loss_q <= 1'b0;
        end
    end

    // outbound bit source; national bits win over d/e and timeslot 16
    always_comb begin
        tx_bit_d = ser_s;
        if (slot.nat_bit) begin
            case (code)
                `EOSF_CODE_ONES:     tx_bit_d = 1'b1;
                `EOSF_CODE_CAS_ONES: tx_bit_d = 1'b1;
                default:             tx_bit_d = dl_bit;
            endcase
        end else if (slot.de_slot) begin
            if (code == `EOSF_CODE_SIG_DE) begin
                tx_bit_d = srcx_q[`EOSF_ALT_PIN_BIT] ? sig_s : ser_s;
            end else begin
                tx_bit_d = srcx_q[`EOSF_ALT_PIN_BIT] ? fd_s : ser_s;
            end
        end else if (slot.ts16) begin
            case (code)
                `EOSF_CODE_ONES: begin
                    tx_bit_d = (ts16_src == EOSF_TS16_SERIAL) ? ser_s : sig_s;
                end
                `EOSF_CODE_CAS_DL, `EOSF_CODE_CAS_ONES: begin
                    case (ts16_src)
                        EOSF_TS16_SLOTREG:  tx_bit_d = slot_sig_bit;
                        EOSF_TS16_OVERHEAD: tx_bit_d = oh_s;
                        EOSF_TS16_SIGNAL:   tx_bit_d = sig_s;
                        default:            tx_bit_d = ser_s;
                    endcase
                end
                default: tx_bit_d = ser_s;
            endcase
        end
    end

    // registered outbound bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_out_q <= 1'b1;
        end else begin
            tx_out_q <= tx_bit_d;
        end
    end

    // read data one cycle after the strobe, unmapped reads as zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `EOSF_TSDL_OFS: reg_rdata_q <= tsdl_q;
                `EOSF_FCR_OFS:  reg_rdata_q <= fcr_q;
                `EOSF_SRCX_OFS: reg_rdata_q <= srcx_q;
                `EOSF_STAT_OFS: reg_rdata_q <= {6'h00, rx_ev.in_sync, cas_loss_q};
                default:        reg_rdata_q <= 8'h00;
            endcase
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end

    // checks
    sequence s_two_errs;
        rx_ev.mfas_err && !rx_ev.mfas_ok ##1 (!rx_ev.mfas_ok && !rx_restart_q)[*1]
            ##1 rx_ev.mfas_err && !rx_ev.mfas_ok && !rx_restart_q;
    endsequence

    sequence s_reframe_write;
        wr_fcr && reg_wdata[`EOSF_REFRAME_BIT];
    endsequence

    a_restart_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        s_reframe_write |=> rx_restart_q)
        else $error("restart pulse missing after reframe write");

    a_restart_only: assert property (@(posedge clk) disable iff (!rst_n)
        !(wr_fcr && reg_wdata[`EOSF_REFRAME_BIT]) |=> !rx_restart_q)
        else $error("restart pulse without reframe write");

    a_reframe_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (fcr_q[`EOSF_REFRAME_BIT] && !sync_rise && !wr_fcr) |=> fcr_q[`EOSF_REFRAME_BIT])
        else $error("reframe bit dropped before sync");

    a_reframe_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (sync_rise && !wr_fcr) |=> !fcr_q[`EOSF_REFRAME_BIT])
        else $error("reframe bit not cleared on sync");

    a_cas_two_errs: assert property (@(posedge clk) disable iff (!rst_n)
        (casc == `EOSF_CASC_2 && !wr_fcr && err_cnt_q == 4'h0) ##0 s_two_errs |=> cas_loss_q)
        else $error("loss of cas alignment late with criteria 00");

    a_cas_declare: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(cas_loss_q) |-> $past(err_cnt_q) + 4'h1 >= $past(err_thr)
            && $past(rx_ev.mfas_err))
        else $error("loss of cas alignment declared early");

    a_cas_eight: assert property (@(posedge clk) disable iff (!rst_n)
        (casc == `EOSF_CASC_8 && !cas_loss_q) |-> err_cnt_q < `EOSF_CNT_8)
        else $error("eight errors counted without loss");

    a_nat_ones: assert property (@(posedge clk) disable iff (!rst_n)
        (slot.nat_bit && code == `EOSF_CODE_ONES) |=> tx_out_q)
        else $error("national bits not forced to one");

    a_nat_datalink: assert property (@(posedge clk) disable iff (!rst_n)
        (slot.nat_bit && code > `EOSF_CODE_SIG_DE) |=> tx_out_q == $past(dl_bit))
        else $error("unused code did not behave as default");

    a_ts16_default: assert property (@(posedge clk) disable iff (!rst_n)
        (slot.ts16 && !slot.nat_bit && !slot.de_slot && code == `EOSF_CODE_DL)
            |=> tx_out_q == $past(ser_s))
        else $error("timeslot 16 not from serial pin");

    a_ts16_slotreg: assert property (@(posedge clk) disable iff (!rst_n)
        (slot.ts16 && !slot.nat_bit && !slot.de_slot && code == `EOSF_CODE_CAS_DL
            && ts16_src == EOSF_TS16_SLOTREG) |=> tx_out_q == $past(slot_sig_bit))
        else $error("cas timeslot 16 not from slot registers");

    a_de_signal: assert property (@(posedge clk) disable iff (!rst_n)
        (slot.de_slot && !slot.nat_bit && code == `EOSF_CODE_SIG_DE
            && srcx_q[`EOSF_ALT_PIN_BIT]) |=> tx_out_q == $past(sig_s))
        else $error("d/e not from signalling pin");

    a_read_fcr: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `EOSF_FCR_OFS) |=> reg_rdata_q == $past(fcr_q))
        else $error("framing control read back wrong");

    a_cas_clear_ok: assert property (@(posedge clk) disable iff (!rst_n)
        (rx_ev.mfas_ok && !rx_ev.mfas_err) |=> !cas_loss_q && err_cnt_q == 4'h0)
        else $error("good cas word did not end the error run");

    a_cas_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (cas_loss_q && !rx_ev.mfas_ok && !rx_restart_q) |=> cas_loss_q)
        else $error("loss of cas alignment dropped without cause");

    a_cas_restart: assert property (@(posedge clk) disable iff (!rst_n)
        (rx_restart_q && !rx_ev.mfas_err) |=> !cas_loss_q)
        else $error("restart did not clear loss of cas alignment");

    a_nat_default: assert property (@(posedge clk) disable iff (!rst_n)
        (slot.nat_bit && code == `EOSF_CODE_DL) |=> tx_out_q == $past(dl_bit))
        else $error("national bits not from data link");

    a_nat_cas_ones: assert property (@(posedge clk) disable iff (!rst_n)
        (slot.nat_bit && code == `EOSF_CODE_CAS_ONES) |=> tx_out_q)
        else $error("national bits not forced to one with cas");

    a_de_frame: assert property (@(posedge clk) disable iff (!rst_n)
        (slot.de_slot && !slot.nat_bit && code == `EOSF_CODE_DL
            && srcx_q[`EOSF_ALT_PIN_BIT]) |=> tx_out_q == $past(fd_s))
        else $error("d/e not from frame-data pin");

    a_ts16_signal: assert property (@(posedge clk) disable iff (!rst_n)
        (slot.ts16 && !slot.nat_bit && !slot.de_slot && code == `EOSF_CODE_ONES
            && ts16_src != EOSF_TS16_SERIAL) |=> tx_out_q == $past(sig_s))
        else $error("timeslot 16 not from signalling pin");

    a_ts16_overhead: assert property (@(posedge clk) disable iff (!rst_n)
        (slot.ts16 && !slot.nat_bit && !slot.de_slot && code == `EOSF_CODE_CAS_ONES
            && ts16_src == EOSF_TS16_OVERHEAD) |=> tx_out_q == $past(oh_s))
        else $error("cas timeslot 16 not from overhead pin");

endmodule

// ===== tb/eosf_bp_model.sv
// backplane terminal equipment model driving the four transmit pins
`timescale 1ns/1ps
module eosf_bp_model (
    input  wire logic       clk,    // framer clock
    input  wire logic       rst_n,  // synchronous reset, active low
    input  wire logic [3:0] level,  // wanted levels from the bench
    output logic      [3:0] pins_q  // serial, frame-data, signalling, overhead
);
    // launch just after an edge; reset pattern is mixed so no pin looks idle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins_q <= 4'h5;
        end else begin
            pins_q <= level;
        end
    end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the overhead source and framing control block
`timescale 1ns/1ps
`include "eosf_regs.svh"
module tb_top;
    import eosf_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata_q;
    logic [3:0]  pin_lvl = 4'h0;
    logic [3:0]  pins;
    logic        dl_bit = 1'b0;
    logic        slot_sig_bit = 1'b0;
    eosf_slot_s  slot = '0;
    eosf_rx_s    rx_ev = '0;
    logic        tx_out_q;
    logic        rx_restart_q;
    logic        cas_loss_q;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          need [4] = '{2, 3, 4, 8};
    logic [15:0] cases [20];
    always #4 clk = ~clk;
    eosf_bp_model eosf_bp_model_inst (.clk(clk), .rst_n(rst_n), .level(pin_lvl), .pins_q(pins));
    eosf_ctrl eosf_ctrl_inst (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .tx_frame_data_in(pins[2]), .tx_serial_in(pins[3]), .tx_signalling_in(pins[1]),
        .tx_overhead_in(pins[0]), .dl_bit(dl_bit), .slot_sig_bit(slot_sig_bit),
        .slot(slot), .rx_ev(rx_ev), .tx_out_q(tx_out_q), .rx_restart_q(rx_restart_q),
        .cas_loss_q(cas_loss_q)
    );
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata_q, exp);
    endtask
    // one receive event pulse, returning just after it lands so the caller can look at the loss flag
    task automatic ev(input logic err);
        @(posedge clk);
        rx_ev.mfas_err <= err;
        rx_ev.mfas_ok  <= ~err;
        @(posedge clk);
        rx_ev.mfas_err <= 1'b0;
        rx_ev.mfas_ok  <= 1'b0;
        #1;
    endtask
    // pins pass a model flop and a two-flop synchroniser, so settle five edges
    task automatic mux(input logic [5:0] src, input logic [2:0] s, input logic e);
        @(posedge clk);
        pin_lvl      <= src[5:2];
        dl_bit       <= src[1];
        slot_sig_bit <= src[0];
        repeat (5) @(posedge clk);
        slot <= s;
        @(posedge clk);
        slot <= '0;
        #1;
        chk({7'h00, tx_out_q}, {7'h00, e});
    endtask
    // code, alt select, strobe, forced-ones, one-hot source {ser,frm,sig,oh,dl,reg}
    initial begin
        cases[0]  = {3'h0, 3'h0, 3'h4, 1'b0, 6'h02};
        cases[1]  = {3'h0, 3'h0, 3'h1, 1'b0, 6'h20};
        cases[2]  = {3'h0, 3'h4, 3'h2, 1'b0, 6'h10};
        cases[3]  = {3'h0, 3'h0, 3'h2, 1'b0, 6'h20};
        cases[4]  = {3'h4, 3'h4, 3'h2, 1'b0, 6'h08};
        cases[5]  = {3'h4, 3'h0, 3'h4, 1'b0, 6'h02};
        cases[6]  = {3'h4, 3'h0, 3'h1, 1'b0, 6'h20};
        cases[7]  = {3'h2, 3'h0, 3'h4, 1'b1, 6'h00};
        cases[8]  = {3'h2, 3'h1, 3'h1, 1'b0, 6'h08};
        cases[9]  = {3'h1, 3'h0, 3'h4, 1'b0, 6'h02};
        cases[10] = {3'h1, 3'h1, 3'h1, 1'b0, 6'h01};
        cases[11] = {3'h3, 3'h2, 3'h1, 1'b0, 6'h04};
        cases[12] = {3'h3, 3'h3, 3'h1, 1'b0, 6'h08};
        cases[13] = {3'h5, 3'h0, 3'h4, 1'b0, 6'h02};
        cases[14] = {3'h7, 3'h0, 3'h1, 1'b0, 6'h20};
        cases[15] = {3'h3, 3'h0, 3'h4, 1'b1, 6'h00};
        cases[16] = {3'h1, 3'h0, 3'h1, 1'b0, 6'h20};
        cases[17] = {3'h2, 3'h0, 3'h1, 1'b0, 6'h20};
        cases[18] = {3'h1, 3'h4, 3'h2, 1'b0, 6'h10};
        cases[19] = {3'h4, 3'h0, 3'h2, 1'b0, 6'h20};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(`EOSF_TSDL_OFS, 8'h00);
        rd(`EOSF_FCR_OFS, 8'h40);
        rd(12'h1ff, 8'h00);
        // each source alone high, then alone low among all others high
        for (int i = 0; i < 20; i++) begin
            wr(`EOSF_TSDL_OFS, {5'h00, cases[i][15:13]});
            wr(`EOSF_SRCX_OFS, {5'h00, cases[i][12:10]});
            mux(cases[i][5:0], cases[i][9:7], 1'b1);
            mux(~cases[i][5:0], cases[i][9:7], cases[i][6]);
        end
        rd(`EOSF_TSDL_OFS, 8'h04);
        // every loss criterion: one short of the count holds off, the next declares
        for (int c = 0; c < 4; c++) begin
            wr(`EOSF_FCR_OFS, {1'b0, c[1:0], 5'h00});
            ev(1'b0);
            chk({7'h00, cas_loss_q}, 8'h00);
            repeat (need[c] - 1) ev(1'b1);
            chk({7'h00, cas_loss_q}, 8'h00);
            ev(1'b1);
            chk({7'h00, cas_loss_q}, 8'h01);
        end
        rd(`EOSF_STAT_OFS, 8'h01);
        wr(`EOSF_FCR_OFS, 8'hc0);
        chk({7'h00, rx_restart_q}, 8'h01);
        @(posedge clk);
        #1;
        chk({7'h00, rx_restart_q}, 8'h00);
        chk({7'h00, cas_loss_q}, 8'h00);
        rd(`EOSF_FCR_OFS, 8'hc0);
        @(posedge clk);
        rx_ev.in_sync <= 1'b1;
        repeat (2) @(posedge clk);
        rd(`EOSF_FCR_OFS, 8'h40);
        rd(`EOSF_STAT_OFS, 8'h02);
        finish_test();
    end
    // the whole run takes under five hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
endmodule
